// file: core/qrfs_defs.svh
// timing counts, register offsets and reset values for the qr sequencer
`ifndef QRFS_DEFS_SVH
`define QRFS_DEFS_SVH

`define QRFS_CLK_NS 40
`define QRFS_BLANK_MIN_NS 4160
`define QRFS_BLANK_MAX_NS 16000
`define QRFS_FMAX_KHZ 240
`define QRFS_FORCE_NS 2700
`define QRFS_VALLEY_NS 197
`define QRFS_STARTER_NS 100000
`define QRFS_ON_MAX_NS 20000
`define QRFS_RESTART_S 2

`define QRFS_BLANK_MIN_CYC \
	((`QRFS_BLANK_MIN_NS + `QRFS_CLK_NS - 1) / `QRFS_CLK_NS)
`define QRFS_BLANK_MAX_CYC (`QRFS_BLANK_MAX_NS / `QRFS_CLK_NS)
`define QRFS_MIN_PERIOD_CYC \
	((1000000 + `QRFS_FMAX_KHZ * `QRFS_CLK_NS - 1) / \
	(`QRFS_FMAX_KHZ * `QRFS_CLK_NS))
`define QRFS_BLANK_SPAN (`QRFS_BLANK_MAX_CYC - `QRFS_BLANK_MIN_CYC)
`define QRFS_FORCE_CYC ((`QRFS_FORCE_NS + `QRFS_CLK_NS - 1) / `QRFS_CLK_NS)
`define QRFS_VALLEY_CYC \
	((`QRFS_VALLEY_NS + `QRFS_CLK_NS - 1) / `QRFS_CLK_NS)
`define QRFS_STARTER_CYC (`QRFS_STARTER_NS / `QRFS_CLK_NS)
`define QRFS_ON_MAX_CYC (`QRFS_ON_MAX_NS / `QRFS_CLK_NS)
`define QRFS_RESTART_CYC (`QRFS_RESTART_S * 1000000000 / `QRFS_CLK_NS)

`define QRFS_ADDR_CTRL 4'h0
`define QRFS_ADDR_FB 4'h1
`define QRFS_ADDR_LINE 4'h2
`define QRFS_ADDR_STATUS 4'h3
`define QRFS_ADDR_LOCK 4'h4
`define QRFS_ADDR_BLANK 4'h5

`define QRFS_CTRL_RESET 8'h01
`define QRFS_FB_RESET 8'hff
`define QRFS_LINE_RESET 8'h00

`endif

// file: core/qrfs_pkg.sv
// types shared by the qr flyback switch sequencer
package qrfs_pkg;

	typedef enum logic [2:0] {
		ST_CHARGE,
		ST_SEQ,
		ST_RUN,
		ST_FAULT
	} qrfs_state_type;

	// comparator flags, each high while the analog level is above its trip
	typedef struct packed {
		logic supply_fold;
		logic regulator_on;
		logic supply_on;
		logic supply_off;
		logic driver_good_set;
		logic driver_good_clr;
		logic driver_ov;
		logic burst_hi;
		logic burst_lo;
		logic lock_hi;
		logic lock_lo;
		logic zd_arm;
		logic zd_trig;
		logic trim_low;
		logic thermal;
		logic rect_short;
		logic peak_limit;
	} qrfs_flags_type;

	typedef struct packed {
		logic charge_en;
		logic charge_full;
		logic regulator_en;
		logic first_start_switch;
		logic gate_pulldown_switch;
		logic line_sense_connect_switch;
		logic low_side_sense;
	} qrfs_sw_type;

endpackage : qrfs_pkg

// file: core/qrfs_sequencer.sv
// quasi-resonant flyback switch sequencer: start-up, trigger and burst
`timescale 1ns/1ps
`include "qrfs_defs.svh"

module qrfs_sequencer
	import qrfs_pkg::*;
#(
	parameter int unsigned RESTART_CYC = `QRFS_RESTART_CYC
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire qrfs_flags_type flags_in,
	input wire logic [3:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [7:0] reg_rdata_out,
	output qrfs_sw_type switches_out,
	output logic gate_drive_out
);

	localparam logic [11:0] BLANK_MIN = 12'(`QRFS_BLANK_MIN_CYC);
	localparam logic [11:0] MIN_PERIOD = 12'(`QRFS_MIN_PERIOD_CYC);
	localparam logic [8:0] BLANK_SPAN = 9'(`QRFS_BLANK_SPAN);
	localparam logic [11:0] FORCE_CYC = 12'(`QRFS_FORCE_CYC);
	localparam logic [11:0] STARTER_CYC = 12'(`QRFS_STARTER_CYC);
	localparam logic [11:0] ON_MAX_CYC = 12'(`QRFS_ON_MAX_CYC);
	localparam logic [2:0] VALLEY_CYC = 3'(`QRFS_VALLEY_CYC);
	localparam logic [25:0] RESTART_LAST = 26'(RESTART_CYC - 1);

	// two-stage synchroniser on every comparator flag
	qrfs_flags_type meta_reg;
	qrfs_flags_type sync_reg;
	qrfs_flags_type prev_reg;

	qrfs_state_type state_reg;
	qrfs_state_type state_next;
	qrfs_sw_type sw_reg;
	qrfs_sw_type sw_next;
	logic [2:0] step_reg;
	logic [25:0] restart_reg;

	logic [7:0] ctrl_reg;
	logic [7:0] fb_reg;
	logic [7:0] line_reg;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;

	logic drv_ok_reg;
	logic burst_run_reg;
	logic lock_en_reg;
	logic trim_off_reg;
	logic armed_reg;
	logic ever_armed_reg;
	logic on_reg;
	logic gate_reg;
	logic pend_reg;
	logic [2:0] dly_reg;
	logic [11:0] cyc_reg;
	logic [11:0] on_cnt_reg;
	logic [3:0] vcnt_reg;
	logic [3:0] lock_cnt_reg;
	logic lock_valid_reg;
	logic [11:0] blank_reg;

	wire logic zd_fall;
	wire logic zd_rise;
	wire logic run_ok;
	wire logic fire;
	wire logic qualify;
	wire logic blank_done;
	wire logic force_due;
	wire logic starter_due;
	wire logic fault_hit;
	wire logic on_end;
	wire logic [16:0] fb_prod;
	wire logic [11:0] blank_fb;
	wire logic [11:0] blank_trim;
	wire logic [11:0] blank_sum;
	wire logic [11:0] blank_len;
	wire logic [7:0] status_word;
	wire logic bus_wr_ctrl;
	wire logic bus_wr_fb;
	wire logic bus_wr_line;
	wire logic lock_hit;
	wire logic period_ok;
	wire logic [11:0] fb_scaled;
	wire logic gate_next;
	wire logic [2:0] step_next;
	wire logic [25:0] restart_next;
	wire logic lock_capture;
	wire logic zd_count;
	wire logic drv_set;
	wire logic drv_clr;
	wire logic burst_set;
	wire logic burst_clr;
	wire logic lock_set;
	wire logic lock_clr;

	// flags cross in from the analog side
	always_ff @(posedge clk_in) begin
		meta_reg <= flags_in;
		sync_reg <= meta_reg;
		prev_reg <= sync_reg;
	end

	// edge detection on the synchronised zero-detect flags
	assign zd_fall = prev_reg.zd_trig & ~sync_reg.zd_trig;
	assign zd_rise = ~prev_reg.zd_arm & sync_reg.zd_arm;

	// register bus decode
	assign bus_wr_ctrl = reg_wr_in & (reg_addr_in == `QRFS_ADDR_CTRL);
	assign bus_wr_fb = reg_wr_in & (reg_addr_in == `QRFS_ADDR_FB);
	assign bus_wr_line = reg_wr_in & (reg_addr_in == `QRFS_ADDR_LINE);

	assign status_word = {1'b0, state_reg[1:0], lock_valid_reg,
		armed_reg, burst_run_reg, drv_ok_reg, trim_off_reg};

	always_comb begin
		rdata_next = 8'h00;
		if (reg_rd_in) begin
			case (reg_addr_in)
				`QRFS_ADDR_CTRL: rdata_next = ctrl_reg;
				`QRFS_ADDR_FB: rdata_next = fb_reg;
				`QRFS_ADDR_LINE: rdata_next = line_reg;
				`QRFS_ADDR_STATUS: rdata_next = status_word;
				`QRFS_ADDR_LOCK: rdata_next = {4'h0, lock_cnt_reg};
				`QRFS_ADDR_BLANK: rdata_next = blank_reg[11:4];
				default: rdata_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			ctrl_reg <= `QRFS_CTRL_RESET;
			fb_reg <= `QRFS_FB_RESET;
			line_reg <= `QRFS_LINE_RESET;
			rdata_reg <= 8'h00;
		end else begin
			if (bus_wr_ctrl)
				ctrl_reg <= reg_wdata_in;
			if (bus_wr_fb)
				fb_reg <= reg_wdata_in;
			if (bus_wr_line)
				line_reg <= reg_wdata_in;
			rdata_reg <= rdata_next;
		end
	end

	// feedback code 0 sits at burst threshold, 255 at frequency reduction
	assign fb_prod = 17'(BLANK_SPAN) * 17'(8'hff - fb_reg);
	// divide by full scale so code 0 lands exactly on the maximum
	assign fb_scaled = 12'(fb_prod / 17'h0_00ff);
	assign blank_fb = BLANK_MIN + fb_scaled;
	// trim raises the blanking by two cycles per line code step
	assign blank_trim = trim_off_reg ? 12'h000 :
		{3'b000, line_reg, 1'b0};
	assign blank_sum = blank_fb + blank_trim;
	// floor keeps the period clear of the frequency ceiling
	assign blank_len = (blank_sum < MIN_PERIOD) ? MIN_PERIOD : blank_sum;

	// trigger qualification
	assign blank_done = (cyc_reg >= blank_reg);
	// lock ignores blanking, so the period floor is kept here
	assign period_ok = (cyc_reg >= MIN_PERIOD);
	// the locked edge is the one that brings the count to the latch
	assign lock_hit = (4'(vcnt_reg + 4'h1) == lock_cnt_reg) &
		period_ok;
	assign qualify = zd_fall & armed_reg & ~on_reg & ~pend_reg &
		(lock_valid_reg ? lock_hit : blank_done);
	assign zd_count = zd_fall & ~on_reg & (vcnt_reg != 4'hf);
	assign gate_next = on_reg & run_ok & ~sync_reg.driver_ov;
	assign lock_capture = fire & ~lock_valid_reg &
		(vcnt_reg != 4'h0);
	assign force_due = ever_armed_reg & ~on_reg & ~pend_reg &
		(cyc_reg >= blank_reg + FORCE_CYC);
	assign starter_due = ~ever_armed_reg & ~on_reg & ~pend_reg &
		(cyc_reg >= STARTER_CYC);

	assign run_ok = (state_reg == ST_RUN) & drv_ok_reg & burst_run_reg &
		ctrl_reg[0];
	assign fire = run_ok & ((pend_reg & (dly_reg == 3'h0)) |
		force_due | starter_due);
	assign on_end = on_reg & (sync_reg.peak_limit |
		(on_cnt_reg >= ON_MAX_CYC));
	assign fault_hit = sync_reg.thermal | sync_reg.rect_short;

	// start-up sequencer
	always_comb begin
		state_next = state_reg;
		sw_next = sw_reg;
		sw_next.charge_full = sync_reg.supply_fold;
		if (sync_reg.regulator_on)
			sw_next.regulator_en = 1'b1;
		case (state_reg)
			ST_CHARGE: begin
				sw_next.charge_en = 1'b1;
				sw_next.first_start_switch = 1'b1;
				sw_next.gate_pulldown_switch = 1'b0;
				sw_next.line_sense_connect_switch = 1'b0;
				sw_next.low_side_sense = 1'b0;
				if (sync_reg.supply_on)
					state_next = ST_SEQ;
			end
			ST_SEQ: begin
				// one switch per cycle, in the fixed order
				case (step_reg)
					3'h0: sw_next.charge_en = 1'b0;
					3'h1: sw_next.first_start_switch = 1'b0;
					3'h2: sw_next.gate_pulldown_switch = 1'b1;
					3'h3: sw_next.line_sense_connect_switch = 1'b1;
					3'h4: sw_next.low_side_sense = 1'b1;
					default: state_next = ST_RUN;
				endcase
			end
			ST_RUN: begin
				if (fault_hit)
					state_next = ST_FAULT;
			end
			ST_FAULT: begin
				if (restart_reg == RESTART_LAST)
					state_next = ST_RUN;
			end
			default: state_next = ST_CHARGE;
		endcase
		// supply collapse overrides everything
		if (state_reg != ST_CHARGE && !sync_reg.supply_off)
			state_next = ST_CHARGE;
	end

	assign step_next = (state_reg == ST_SEQ) ? step_reg + 3'h1 : 3'h0;
	assign restart_next = (state_reg == ST_FAULT) ?
		restart_reg + 26'h000_0001 : 26'h000_0000;

	// all control state clears under lockout
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			state_reg <= ST_CHARGE;
			sw_reg <= '0;
			step_reg <= 3'h0;
			restart_reg <= 26'h000_0000;
		end else begin
			state_reg <= state_next;
			sw_reg <= sw_next;
			step_reg <= step_next;
			restart_reg <= restart_next;
		end
	end

	// hysteresis set and clear conditions, set has priority
	assign drv_set = sync_reg.driver_good_set;
	assign drv_clr = ~sync_reg.driver_good_clr;
	assign burst_set = sync_reg.burst_hi;
	assign burst_clr = ~sync_reg.burst_lo;
	assign lock_set = sync_reg.lock_hi;
	assign lock_clr = ~sync_reg.lock_lo;

	// hysteretic condition flags
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			drv_ok_reg <= 1'b0;
			burst_run_reg <= 1'b0;
			lock_en_reg <= 1'b0;
			trim_off_reg <= 1'b0;
		end else begin
			if (drv_set)
				drv_ok_reg <= 1'b1;
			else if (drv_clr)
				drv_ok_reg <= 1'b0;
			if (burst_set)
				burst_run_reg <= 1'b1;
			else if (burst_clr)
				burst_run_reg <= 1'b0;
			if (lock_set)
				lock_en_reg <= 1'b1;
			else if (lock_clr)
				lock_en_reg <= 1'b0;
			// sampled only while charging, held until next power-on
			if (state_reg == ST_CHARGE)
				trim_off_reg <= sync_reg.trim_low;
		end
	end

	// switching cycle timing
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			armed_reg <= 1'b0;
			ever_armed_reg <= 1'b0;
			on_reg <= 1'b0;
			gate_reg <= 1'b0;
			pend_reg <= 1'b0;
			dly_reg <= 3'h0;
			cyc_reg <= 12'h000;
			on_cnt_reg <= 12'h000;
			vcnt_reg <= 4'h0;
			blank_reg <= BLANK_MIN;
		end else begin
			// arming wins over the clear of a same-cycle turn-on
			if (zd_rise)
				armed_reg <= 1'b1;
			else if (fire)
				armed_reg <= 1'b0;
			if (zd_rise)
				ever_armed_reg <= 1'b1;
			if (fire) begin
				on_reg <= 1'b1;
				pend_reg <= 1'b0;
				cyc_reg <= 12'h000;
				on_cnt_reg <= 12'h000;
				vcnt_reg <= 4'h0;
				blank_reg <= blank_len;
			end else begin
				if (on_end)
					on_reg <= 1'b0;
				if (on_reg)
					on_cnt_reg <= on_cnt_reg + 12'h001;
				if (cyc_reg != 12'hfff)
					cyc_reg <= cyc_reg + 12'h001;
				if (zd_count)
					vcnt_reg <= vcnt_reg + 4'h1;
				if (qualify) begin
					pend_reg <= 1'b1;
					dly_reg <= trim_off_reg ? 3'h0 : VALLEY_CYC;
				end else if (pend_reg && dly_reg != 3'h0) begin
					dly_reg <= dly_reg - 3'h1;
				end
			end
			// stop at once when switching is no longer allowed
			if (!run_ok) begin
				on_reg <= 1'b0;
				pend_reg <= 1'b0;
			end
			gate_reg <= gate_next;
		end
	end

	// valley count captured at the first turn-on with a nonzero count while the lock is enabled, then held
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			lock_cnt_reg <= 4'h0;
			lock_valid_reg <= 1'b0;
		end else if (!lock_en_reg) begin
			lock_valid_reg <= 1'b0;
		end else if (lock_capture) begin
			lock_cnt_reg <= vcnt_reg;
			lock_valid_reg <= 1'b1;
		end
	end

	assign reg_rdata_out = rdata_reg;
	assign switches_out = sw_reg;
	assign gate_drive_out = gate_reg;

endmodule : qrfs_sequencer

// file: tb/qrfs_sequencer_assertions.sv
// port assertions for the qr flyback switch sequencer
`timescale 1ns/1ps
module qrfs_sequencer_checker
	import qrfs_pkg::*;
#(
	parameter int unsigned RESTART_CYC = 200
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire qrfs_flags_type flags_in,
	input wire logic [3:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_rdata_out,
	input wire qrfs_sw_type switches_out,
	input wire logic gate_drive_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	// cycles since turn-on, saturating so the first pulse is free
	logic [8:0] gap_reg;
	always_ff @(posedge clk_in) begin
		if (!rst_n_in)
			gap_reg <= 9'h1ff;
		else if ($rose(gate_drive_out))
			gap_reg <= 9'h000;
		else if (gap_reg != 9'h1ff)
			gap_reg <= gap_reg + 9'h001;
	end
	// five cycles cover the two-stage sync plus the output register
	property p_no_fire(c);
		c [*5] |=> !$rose(gate_drive_out);
	endproperty
	sequence s_unhook;
		$fell(switches_out.first_start_switch)
			##1 $rose(switches_out.gate_pulldown_switch);
	endsequence
	sequence s_connect;
		$rose(switches_out.line_sense_connect_switch)
			##1 $rose(switches_out.low_side_sense);
	endsequence
	a_reset_clears: assert property ($rose(rst_n_in) |->
		switches_out == 7'h00 && !gate_drive_out ##1
		switches_out.charge_en && switches_out.first_start_switch)
		else $error("outputs not cleared by reset");
	a_fold_reduced: assert property (!flags_in.supply_fold [*5]
		##0 switches_out.charge_en |-> !switches_out.charge_full)
		else $error("charge current not reduced");
	a_fold_full: assert property (flags_in.supply_fold [*5]
		##0 switches_out.charge_en |-> switches_out.charge_full)
		else $error("charge current not full");
	a_regulator_on: assert property (flags_in.regulator_on [*5]
		##0 switches_out.charge_en |-> switches_out.regulator_en)
		else $error("regulator not enabled");
	a_start_order: assert property ($fell(switches_out.charge_en)
		|=> s_unhook ##1 s_connect) else $error("start order broken");
	a_ov_masks: assert property (flags_in.driver_ov [*5]
		|-> !gate_drive_out) else $error("gate driven in overvoltage");
	a_drv_low: assert property (
		p_no_fire(!flags_in.driver_good_clr))
		else $error("fired with driver supply low");
	a_burst_stop: assert property (p_no_fire(!flags_in.burst_lo))
		else $error("fired in burst off phase");
	a_fault_stop: assert property (
		p_no_fire(flags_in.thermal || flags_in.rect_short))
		else $error("fired during fault");
	a_supply_off: assert property (!flags_in.supply_off [*5]
		|-> !gate_drive_out && switches_out.charge_en)
		else $error("not back to charging");
	a_min_period: assert property ($rose(gate_drive_out)
		|-> gap_reg >= 9'h068) else $error("turn-on period too short");
	a_on_bound: assert property ($rose(gate_drive_out)
		|-> ##[1:502] !gate_drive_out) else $error("gate on too long");
	a_rdata_idle: assert property (!$past(reg_rd_in)
		|| $past(reg_addr_in) > 4'h5 |-> reg_rdata_out == 8'h00)
		else $error("read data outside read slot");
endmodule : qrfs_sequencer_checker

bind qrfs_sequencer qrfs_sequencer_checker #(.RESTART_CYC(RESTART_CYC)) chk_u (
	.clk_in(clk_in), .rst_n_in(rst_n_in), .flags_in(flags_in),
	.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
	.reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
	.reg_rdata_out(reg_rdata_out), .switches_out(switches_out),
	.gate_drive_out(gate_drive_out)
);

// file: tb/qrfs_winding_model.sv
// winding and peak-current model driving the zero-detect flags
`timescale 1ns/1ps
module qrfs_winding_model
	import qrfs_pkg::*;
(
	input wire logic clk_in,
	input wire logic gate_in,
	input wire logic ring_en_in,
	input wire logic [7:0] ring_half_in,
	output qrfs_flags_type flags_out
);
	logic [9:0] on_reg = 10'h000;
	logic [9:0] off_reg = 10'h000;
	logic [7:0] ph_reg = 8'h00;
	logic zd_reg = 1'b0;
	always @(posedge clk_in) begin
		if (gate_in) begin
			on_reg <= on_reg + 10'h001;
			off_reg <= 10'h000;
			ph_reg <= 8'h00;
			zd_reg <= 1'b0;
		end else begin
			on_reg <= 10'h000;
			if (off_reg != 10'h3ff)
				off_reg <= off_reg + 10'h001;
			ph_reg <= (ph_reg >= ring_half_in) ? 8'h01 : ph_reg + 8'h01;
			// ringing decays, so late valleys stop reaching the trip
			if (ph_reg == 8'h00 || ph_reg >= ring_half_in)
				zd_reg <= ring_en_in && off_reg < 10'h3c0 && !zd_reg;
		end
	end
	always_comb begin
		flags_out = '0;
		flags_out.zd_arm = zd_reg;
		flags_out.zd_trig = zd_reg;
		flags_out.peak_limit = on_reg >= 10'h014;
	end
endmodule : qrfs_winding_model

// file: tb/qrfs_sequencer_tb_top.sv
// randomised bench for the qr flyback switch sequencer
`timescale 1ns/1ps
module qrfs_sequencer_tb_top
	import qrfs_pkg::*;
	;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	qrfs_flags_type env = '0;
	qrfs_flags_type pf;
	wire qrfs_flags_type fl = env | pf;
	logic [3:0] addr = 4'h0;
	logic [7:0] wd = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic ring = 1'b0;
	logic [7:0] half = 8'h0c;
	logic [7:0] rdat;
	qrfs_sw_type sw;
	logic gate;
	logic gq = 1'b0;
	logic [31:0] seed = 32'h0000_98b0;
	logic [7:0] v, fbv, lnv;
	int rises = 0;
	int bad_count = 0;
	int comparisons = 0;
	int k;
	initial begin
		forever #20 clk = ~clk;
	end
	qrfs_sequencer #(.RESTART_CYC(200)) dut_u (
		.clk_in(clk), .rst_n_in(rst_n), .flags_in(fl),
		.reg_addr_in(addr), .reg_wdata_in(wd), .reg_wr_in(wr),
		.reg_rd_in(rd), .reg_rdata_out(rdat), .switches_out(sw),
		.gate_drive_out(gate)
	);
	qrfs_winding_model pm_u (
		.clk_in(clk), .gate_in(gate), .ring_en_in(ring),
		.ring_half_in(half), .flags_out(pf)
	);
	always @(posedge clk) begin
		gq <= gate;
		if (gate === 1'b1 && gq === 1'b0)
			rises <= rises + 1;
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs
	// upper bits of the blanking count, linear in feedback plus line trim
	function automatic logic [7:0] blank_exp(input logic [7:0] f, l);
		int c;
		c = 400 - (296 * f) / 255 + 2 * l;
		return 8'(c >> 4);
	endfunction : blank_exp
	task automatic test_done();
		if (bad_count == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : test_done
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		#1;
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t seen %h want %h", $time, seen, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		addr <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask : wr_reg
	task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdat;
		@(posedge clk);
	endtask : rd_reg
	// turn-ons counted after a short settle, so no edge straddles the start
	task automatic run(input int n, output int c);
		int r;
		tick(6);
		r = rises;
		tick(n);
		c = rises - r;
	endtask : run
	task automatic power_up();
		env.supply_off <= 1'b1;
		tick(6);
		chk({1'b0, sw}, 8'h48);
		env.supply_fold <= 1'b1;
		tick(6);
		chk({1'b0, sw}, 8'h68);
		env.regulator_on <= 1'b1;
		tick(6);
		chk({1'b0, sw}, 8'h78);
		env.supply_on <= 1'b1;
		tick(12);
		chk({3'h0, sw.charge_en, sw.first_start_switch,
			sw.gate_pulldown_switch, sw.line_sense_connect_switch,
			sw.low_side_sense}, 8'h07);
	endtask : power_up
	initial begin
		repeat (60000) @(posedge clk);
		bad_count++;
		test_done();
	end
	initial begin
		tick(8);
		rst_n <= 1'b1;
		power_up();
		rd_reg(4'h0, v);
		chk(v, 8'h01);
		rd_reg(4'h1, v);
		chk(v, 8'hff);
		rd_reg(4'hf, v);
		chk(v, 8'h00);
		env.burst_hi <= 1'b1;
		env.burst_lo <= 1'b1;
		run(3000, k);
		chk(8'(k), 8'h00);
		env.driver_good_set <= 1'b1;
		env.driver_good_clr <= 1'b1;
		tick(4);
		env.driver_good_set <= 1'b0;
		run(5200, k);
		chk(8'(k > 1 && k < 4), 8'h01);
		ring <= 1'b1;
		run(2000, k);
		chk(8'(k > 3), 8'h01);
		rd_reg(4'h3, v);
		chk(v & 8'h67, 8'h46);
		for (int i = 0; i < 2; i++) begin
			seed = xs(seed);
			fbv = i ? 8'hff : 8'h00;
			lnv = i ? seed[15:8] : 8'h00;
			half <= 8'h04 + {4'h0, seed[3:0]};
			wr_reg(4'h1, fbv);
			wr_reg(4'h2, lnv);
			tick(1500);
			rd_reg(4'h5, v);
			chk(v, blank_exp(fbv, lnv));
		end
		wr_reg(4'h2, 8'h00);
		ring <= 1'b0;
		tick(300);
		run(1720, k);
		chk(8'(k > 8 && k < 12), 8'h01);
		ring <= 1'b1;
		half <= 8'h0c;
		for (int i = 0; i < 3; i++) begin
			env.lock_lo <= i != 1;
			env.lock_hi <= i == 0;
			tick(1000);
			rd_reg(4'h3, v);
			chk(v & 8'h10, (i == 0) ? 8'h10 : 8'h00);
		end
		env.lock_lo <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			wr_reg(4'h0, {7'h00, i != 3});
			env.driver_ov <= i == 0;
			env.burst_hi <= i == 0 || i == 3;
			env.burst_lo <= i != 1;
			run(1000, k);
			chk(8'(k), 8'h00);
		end
		wr_reg(4'h0, 8'h01);
		run(1000, k);
		chk(8'(k > 0), 8'h01);
		for (int i = 0; i < 2; i++) begin
			env.thermal <= i == 0;
			env.rect_short <= i == 1;
			tick(6);
			env.thermal <= 1'b0;
			env.rect_short <= 1'b0;
			rd_reg(4'h3, v);
			chk(v & 8'h60, 8'h60);
			run(150, k);
			chk(8'(k), 8'h00);
			run(700, k);
			chk(8'(k > 0), 8'h01);
		end
		env.supply_off <= 1'b0;
		env.supply_on <= 1'b0;
		tick(6);
		chk({gate, sw}, 8'h78);
		rst_n <= 1'b0;
		env.supply_fold <= 1'b0;
		env.regulator_on <= 1'b0;
		env.trim_low <= 1'b1;
		env.driver_good_set <= 1'b1;
		tick(3);
		rst_n <= 1'b1;
		power_up();
		env.trim_low <= 1'b0;
		rd_reg(4'h2, v);
		chk(v, 8'h00);
		wr_reg(4'h2, 8'h40);
		tick(1500);
		rd_reg(4'h5, v);
		chk(v, blank_exp(8'hff, 8'h00));
		rd_reg(4'h3, v);
		chk(v & 8'h01, 8'h01);
		test_done();
	end
endmodule : qrfs_sequencer_tb_top
